/* File: rtl/asr_map.vh */
// Register map, field positions, reset values and tick counts of the serial block
`ifndef ASR_MAP_VH
`define ASR_MAP_VH

// Byte offsets on the APB
`define ASR_OFF_CTRL        8'h00
`define ASR_OFF_AUX         8'h04
`define ASR_OFF_BAUD        8'h08
`define ASR_OFF_STAT        8'h0c
`define ASR_OFF_MASK        8'h10
`define ASR_OFF_DATA        8'h14

// Control register fields
`define ASR_C_TXEMPTY_IRQ   7
`define ASR_C_TXDONE_IRQ    6
`define ASR_C_RXFULL_IRQ    5
`define ASR_C_QUIET_IRQ     4
`define ASR_C_TXPATH        3
`define ASR_C_RXPATH        2
`define ASR_C_SLEEP         1
`define ASR_C_BREAK         0

// Auxiliary register field
`define ASR_A_LONGBRK       0

// Status register fields, mask register has the same layout
`define ASR_S_TXEMPTY       7
`define ASR_S_TXDONE        6
`define ASR_S_RXFULL        5
`define ASR_S_QUIET         4
`define ASR_S_OVERRUN       3
`define ASR_S_NOISE         2
`define ASR_S_FRAME         1

// Reset values
`define ASR_CTRL_RST        8'h00
`define ASR_MASK_RST        8'hff
`define ASR_BAUD_RST        16'h0036

// Receive clock ticks within one bit time
`define ASR_RT_LAST         5'd16
`define ASR_RT_SAMP1        5'd8
`define ASR_RT_SAMP2        5'd9
`define ASR_RT_SAMP3        5'd10
`define ASR_RT_VER1         5'd3
`define ASR_RT_VER2         5'd5
`define ASR_RT_VER3         5'd7

// Character lengths in bit times, idle-line length in receive ticks
`define ASR_DATA_BITS       4'd8
`define ASR_FRAME_BITS      4'd10
`define ASR_BRK_LEN         4'd10
`define ASR_BRK_LONG        4'd13
`define ASR_PRE_LEN         4'd10
`define ASR_QUIET_TICKS     8'd160

`endif

/* File: rtl/asr_vote.v */
// Majority vote and disagreement check over three receive samples
`timescale 1ns/100ps
module asr_vote (
    // Samples, oldest in bit 2
    input  wire [2:0] samples,
    // Decision
    output wire       bitVal,
    output wire       noisy,
    output wire       anyOne
);

    assign bitVal = (samples[2] & samples[1]) | (samples[2] & samples[0]) | (samples[1] & samples[0]);
    assign noisy  = (samples != 3'b000) && (samples != 3'b111);
    assign anyOne = |samples;

endmodule

/* File: rtl/asr_baud.v */
// Receive sampling tick generator, sixteen ticks per bit time
`timescale 1ns/100ps
module asr_baud #(
    parameter W = 16
) (
    // Clock and reset
    input  wire         clk_sys,
    input  wire         rst,
    // Bus clocks per sampling tick
    input  wire [W-1:0] divisor,
    // One-cycle tick
    output reg          rtTick
);

    reg  [W-1:0] cnt_r;
    wire [W-1:0] lastCnt = (divisor == {W{1'b0}}) ? {W{1'b0}} : divisor - {{(W-1){1'b0}}, 1'b1};

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_r  <= {W{1'b0}};
            rtTick <= 1'b0;
        end else if (cnt_r >= lastCnt) begin
            cnt_r  <= {W{1'b0}};
            rtTick <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + {{(W-1){1'b0}}, 1'b1};
            rtTick <= 1'b0;
        end
    end

endmodule

/* File: rtl/asr_top.v */
// Asynchronous serial block: control register, transmitter with break, receiver with sample recovery
// How it works
// - Transmit-empty enable lets the empty transmit buffer flag request an interrupt.
// - Transmit-done enable lets the transmission complete flag request an interrupt.
// - Receive-full enable lets receive full or overrun request an interrupt.
// - Quiet-line enable lets the idle line flag request an interrupt.
// - Transmit path bit enables transmitter, drives the pin; rising edge queues idle preamble.
// - Receive path bit enables the receiver; clear means receiver held idle.
// - Sleep bit puts receiver in standby, blocks its interrupts; idle line clears it.
// - A short pulse on break bit still sends one whole break, 10 or 13 zeros.
// - While the break bit stays set, whole break characters repeat back to back.
// - Each data bit is the majority of samples at ticks eight, nine, ten.
// - Noise flag is set when the three samples of a bit disagree.
// - Mid samples never reject a verified start bit; a one there flags noise.
// - Stop bit with at most one sample high gives framing error; disagreement flags noise.
// - Stop-bit samples serve both stop confirmation and noise detection.
`timescale 1ns/100ps
`include "asr_map.vh"
module asr_top #(
    parameter BAUD_W = 16
) (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // APB slave
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Serial line
    input  wire        rxPin,
    output reg         txOut,
    output reg         txOe,
    // Interrupt
    output reg         irqReq
);

    localparam TX_IDLE  = 2'd0;
    localparam TX_PRE   = 2'd1;
    localparam TX_FRAME = 2'd2;
    localparam TX_BREAK = 2'd3;

    localparam RX_IDLE  = 2'd0;
    localparam RX_START = 2'd1;
    localparam RX_DATA  = 2'd2;
    localparam RX_STOP  = 2'd3;

    // Software-visible state
    reg  [7:0]        ctrl_r;
    reg               longBreak_r;
    reg  [BAUD_W-1:0] baud_r;
    reg  [7:0]        mask_r;
    reg  [7:0]        txBuf_r;
    reg  [7:0]        rxBuf_r;
    reg               txEmpty_r;
    reg               txDone_r;
    reg               rxFull_r;
    reg               quiet_r;
    reg               overrun_r;
    reg               noise_r;
    reg               frame_r;

    // Transmitter
    reg  [1:0]        txState_r;
    reg  [3:0]        txRt_r;
    reg  [3:0]        txBit_r;
    reg  [9:0]        txShift_r;
    reg               txPathPrev_r;
    reg               txPreq_r;
    reg               breakPrev_r;
    reg               brkPend_r;

    // Receiver
    reg               rxMeta_r;
    reg               rxSync_r;
    reg  [1:0]        rxState_r;
    reg  [4:0]        rxRt_r;
    reg  [3:0]        rxBit_r;
    reg  [7:0]        rxShift_r;
    reg  [1:0]        samp_r;
    reg  [1:0]        ver_r;
    reg               rxNoise_r;
    reg  [7:0]        quietCnt_r;
    reg               quietArm_r;

    wire              rtTick;
    wire              midBit;
    wire              midNoisy;
    wire              midAnyOne;
    wire              verBit;
    wire              txEmptyIrqOn   = ctrl_r[`ASR_C_TXEMPTY_IRQ];
    wire              txDoneIrqOn    = ctrl_r[`ASR_C_TXDONE_IRQ];
    wire              rxFullIrqOn    = ctrl_r[`ASR_C_RXFULL_IRQ];
    wire              quietLineIrqOn = ctrl_r[`ASR_C_QUIET_IRQ];
    wire              txPathOn       = ctrl_r[`ASR_C_TXPATH];
    wire              rxPathOn       = ctrl_r[`ASR_C_RXPATH];
    wire              rxSleepWake    = ctrl_r[`ASR_C_SLEEP];
    wire              breakSend      = ctrl_r[`ASR_C_BREAK];

    asr_baud #(
        .W       (BAUD_W)
    ) u_baud (
        .clk_sys (clk_sys),
        .rst     (rst),
        .divisor (baud_r),
        .rtTick  (rtTick)
    );

    asr_vote u_voteMid (
        .samples ({samp_r, rxSync_r}),
        .bitVal  (midBit),
        .noisy   (midNoisy),
        .anyOne  (midAnyOne)
    );

    asr_vote u_voteVer (
        .samples ({ver_r, rxSync_r}),
        .bitVal  (verBit),
        .noisy   (),
        .anyOne  ()
    );

    // APB decode; read data is captured in the setup cycle so pready and prdata both come from flops
    wire setupPh = psel & ~penable;
    wire accessPh = psel & penable & pready;
    wire wrEn = accessPh & pwrite;
    wire rdEn = accessPh & ~pwrite;
    wire hitCtrl = (paddr == `ASR_OFF_CTRL);
    wire hitAux = (paddr == `ASR_OFF_AUX);
    wire hitBaud = (paddr == `ASR_OFF_BAUD);
    wire hitStat = (paddr == `ASR_OFF_STAT);
    wire hitMask = (paddr == `ASR_OFF_MASK);
    wire hitData = (paddr == `ASR_OFF_DATA);
    wire hitAny = hitCtrl | hitAux | hitBaud | hitStat | hitMask | hitData;
    wire [7:0] statVec = {txEmpty_r, txDone_r, rxFull_r, quiet_r, overrun_r, noise_r, frame_r, 1'b0};

    // Only bits that were actually returned are cleared, so an event after the capture survives
    wire rdStat = rdEn & hitStat;
    wire [7:0] statClr = rdStat ? prdata[7:0] : 8'h00;
    wire wrData = wrEn & hitData;
    wire rdData = rdEn & hitData;

    reg [31:0] rdMux;
    always @* begin
        rdMux = 32'h0000_0000;
        case (paddr)
            `ASR_OFF_CTRL: rdMux[7:0] = ctrl_r;
            `ASR_OFF_AUX:  rdMux[0] = longBreak_r;
            `ASR_OFF_BAUD: rdMux[BAUD_W-1:0] = baud_r;
            `ASR_OFF_STAT: rdMux[7:0] = statVec;
            `ASR_OFF_MASK: rdMux[7:0] = mask_r;
            `ASR_OFF_DATA: rdMux[7:0] = rxBuf_r;
            default:       rdMux = 32'h0000_0000;
        endcase
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setupPh;
            if (setupPh) begin
                prdata  <= rdMux;
                pslverr <= ~hitAny;
            end
        end
    end

    // Idle-line detection runs while the receiver waits for a start edge
    wire quietHit = rtTick & (rxState_r == RX_IDLE) & rxSync_r & (quietCnt_r == `ASR_QUIET_TICKS - 8'd1);
    wire wakeEvt = quietHit & rxSleepWake;

    // Software registers
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_r      <= `ASR_CTRL_RST;
            longBreak_r <= 1'b0;
            baud_r      <= `ASR_BAUD_RST;
            mask_r      <= `ASR_MASK_RST;
            txBuf_r     <= 8'h00;
        end else begin
            if (wrEn & hitCtrl) begin
                ctrl_r <= pwdata[7:0];
            end else if (wakeEvt) begin
                ctrl_r[`ASR_C_SLEEP] <= 1'b0;
            end
            if (wrEn & hitAux) begin
                longBreak_r <= pwdata[`ASR_A_LONGBRK];
            end
            if (wrEn & hitBaud) begin
                baud_r <= pwdata[BAUD_W-1:0];
            end
            if (wrEn & hitMask) begin
                mask_r <= pwdata[7:0];
            end
            if (wrData) begin
                txBuf_r <= pwdata[7:0];
            end
        end
    end

    // Transmitter
    wire txBitEnd = rtTick & (txRt_r == 4'hf);
    wire [3:0] brkLast = (longBreak_r ? `ASR_BRK_LONG : `ASR_BRK_LEN) - 4'd1;
    wire txLoad = (txState_r == TX_IDLE) & txPathOn & ~brkPend_r & ~breakSend & ~txPreq_r & ~txEmpty_r;
    reg  txFinish;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            txState_r    <= TX_IDLE;
            txRt_r       <= 4'h0;
            txBit_r      <= 4'h0;
            txShift_r    <= 10'h3ff;
            txPathPrev_r <= 1'b0;
            txPreq_r     <= 1'b0;
            breakPrev_r  <= 1'b0;
            brkPend_r    <= 1'b0;
            txOut        <= 1'b1;
            txOe         <= 1'b0;
            txFinish     <= 1'b0;
        end else begin
            txPathPrev_r <= txPathOn;
            breakPrev_r  <= breakSend;
            txFinish     <= 1'b0;
            if (txPathOn & ~txPathPrev_r) begin
                txPreq_r <= 1'b1;
            end
            if (breakSend & ~breakPrev_r) begin
                brkPend_r <= 1'b1;
            end
            if (txState_r != TX_IDLE) begin
                txRt_r <= rtTick ? txRt_r + 4'h1 : txRt_r;
            end
            case (txState_r)
                TX_IDLE: begin
                    txRt_r  <= 4'h0;
                    txBit_r <= 4'h0;
                    if (txPathOn & (brkPend_r | breakSend)) begin
                        txState_r <= TX_BREAK;
                    end else if (txPathOn & txPreq_r) begin
                        txState_r <= TX_PRE;
                    end else if (txLoad) begin
                        txShift_r <= {1'b1, txBuf_r, 1'b0};
                        txState_r <= TX_FRAME;
                    end
                end
                TX_PRE: begin
                    if (txBitEnd) begin
                        txBit_r <= txBit_r + 4'h1;
                        if (txBit_r == `ASR_PRE_LEN - 4'd1) begin
                            txPreq_r  <= 1'b0;
                            txState_r <= TX_IDLE;
                            txFinish  <= 1'b1;
                        end
                    end
                end
                TX_FRAME: begin
                    if (txBitEnd) begin
                        txShift_r <= {1'b1, txShift_r[9:1]};
                        txBit_r   <= txBit_r + 4'h1;
                        if (txBit_r == `ASR_FRAME_BITS - 4'd1) begin
                            txState_r <= TX_IDLE;
                            txFinish  <= 1'b1;
                        end
                    end
                end
                TX_BREAK: begin
                    if (txBitEnd) begin
                        txBit_r <= txBit_r + 4'h1;
                        if (txBit_r == brkLast) begin
                            brkPend_r <= breakSend & ~breakPrev_r;
                            txBit_r   <= 4'h0;
                            if (~breakSend) begin
                                txState_r <= TX_IDLE;
                                txFinish  <= 1'b1;
                            end
                        end
                    end
                end
                default: txState_r <= TX_IDLE;
            endcase
            // A character in flight is finished even if the path is switched off meanwhile
            txOe <= txPathOn | (txState_r != TX_IDLE);
            txOut <= (txState_r == TX_FRAME) ? txShift_r[0] : (txState_r != TX_BREAK);
        end
    end

    // Receiver
    wire rxActive = rxPathOn;
    wire rxTickIn = rtTick & rxActive & (rxState_r != RX_IDLE);
    wire rxEnd = rxTickIn & (rxState_r == RX_STOP) & (rxRt_r == `ASR_RT_SAMP3);
    wire rxTake = rxEnd & ~rxSleepWake;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rxMeta_r   <= 1'b1;
            rxSync_r   <= 1'b1;
            rxState_r  <= RX_IDLE;
            rxRt_r     <= 5'd0;
            rxBit_r    <= 4'h0;
            rxShift_r  <= 8'h00;
            samp_r     <= 2'b00;
            ver_r      <= 2'b00;
            rxNoise_r  <= 1'b0;
            quietCnt_r <= 8'h00;
            quietArm_r <= 1'b0;
            rxBuf_r    <= 8'h00;
        end else begin
            rxMeta_r <= rxPin;
            rxSync_r <= rxMeta_r;
            if (~rxActive) begin
                rxState_r  <= RX_IDLE;
                quietCnt_r <= 8'h00;
            end else if (rtTick & (rxState_r == RX_IDLE)) begin
                if (~rxSync_r) begin
                    rxState_r  <= RX_START;
                    rxRt_r     <= 5'd1;
                    rxNoise_r  <= 1'b0;
                    quietCnt_r <= 8'h00;
                end else if (quietHit) begin
                    quietCnt_r <= 8'h00;
                    quietArm_r <= 1'b0;
                end else begin
                    quietCnt_r <= quietCnt_r + 8'h01;
                end
            end else if (rxTickIn) begin
                rxRt_r <= (rxRt_r == `ASR_RT_LAST) ? 5'd1 : rxRt_r + 5'd1;
                if ((rxRt_r == `ASR_RT_VER1) | (rxRt_r == `ASR_RT_VER2)) begin
                    ver_r <= {ver_r[0], rxSync_r};
                end
                // Start bit verification uses only the early samples
                if ((rxState_r == RX_START) & (rxRt_r == `ASR_RT_VER3) & verBit) begin
                    rxState_r <= RX_IDLE;
                end
                if ((rxRt_r == `ASR_RT_SAMP1) | (rxRt_r == `ASR_RT_SAMP2)) begin
                    samp_r <= {samp_r[0], rxSync_r};
                end
                if (rxRt_r == `ASR_RT_SAMP3) begin
                    case (rxState_r)
                        RX_START: rxNoise_r <= rxNoise_r | midAnyOne;
                        RX_DATA: begin
                            rxShift_r <= {midBit, rxShift_r[7:1]};
                            rxNoise_r <= rxNoise_r | midNoisy;
                        end
                        RX_STOP: begin
                            rxState_r  <= RX_IDLE;
                            quietArm_r <= 1'b1;
                        end
                        default: rxNoise_r <= rxNoise_r;
                    endcase
                end
                if (rxRt_r == `ASR_RT_LAST) begin
                    if (rxState_r == RX_START) begin
                        rxState_r <= RX_DATA;
                        rxBit_r   <= 4'h0;
                    end else if (rxState_r == RX_DATA) begin
                        rxBit_r <= rxBit_r + 4'h1;
                        if (rxBit_r == `ASR_DATA_BITS - 4'd1) begin
                            rxState_r <= RX_STOP;
                        end
                    end
                end
            end
            if (rxTake & (~rxFull_r | rdData)) begin
                rxBuf_r <= rxShift_r;
            end
        end
    end

    // Status flags; a hardware set in the cycle of a software clear wins
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            txEmpty_r <= 1'b1;
            txDone_r  <= 1'b1;
            rxFull_r  <= 1'b0;
            quiet_r   <= 1'b0;
            overrun_r <= 1'b0;
            noise_r   <= 1'b0;
            frame_r   <= 1'b0;
        end else begin
            // A data write while the buffer is still full replaces the waiting byte
            txEmpty_r <= txLoad | (txEmpty_r & ~wrData);
            txDone_r  <= (txFinish & txEmpty_r & (txState_r == TX_IDLE)) | (txDone_r & ~wrData);
            rxFull_r  <= rxTake | (rxFull_r & ~rdData);
            overrun_r <= (rxTake & rxFull_r & ~rdData) | (overrun_r & ~statClr[`ASR_S_OVERRUN]);
            quiet_r   <= (quietHit & quietArm_r & ~rxSleepWake) | (quiet_r & ~statClr[`ASR_S_QUIET]);
            noise_r   <= (rxTake & (rxNoise_r | midNoisy)) | (noise_r & ~statClr[`ASR_S_NOISE]);
            frame_r   <= (rxTake & ~midBit) | (frame_r & ~statClr[`ASR_S_FRAME]);
        end
    end

    // Interrupt request
    wire [7:0] irqEn = {txEmptyIrqOn,
                        txDoneIrqOn,
                        rxFullIrqOn & ~rxSleepWake,
                        quietLineIrqOn & ~rxSleepWake,
                        rxFullIrqOn & ~rxSleepWake,
                        ~rxSleepWake,
                        ~rxSleepWake,
                        1'b0} & mask_r;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irqReq <= 1'b0;
        end else begin
            irqReq <= |(statVec & irqEn);
        end
    end

endmodule

/* File: bench/asr_top_props.sv */
// Port-level assertions for the serial block
`timescale 1ns/100ps
`include "asr_map.vh"
module asr_top_props (
    // Clock and reset
    input wire        clk_sys,
    input wire        rst,
    // APB
    input wire [7:0]  paddr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // Line and interrupt
    input wire        rxPin,
    input wire        txOut,
    input wire        txOe,
    input wire        irqReq
);
    reg  [7:0] ctrlSh_r;
    reg  [1:0] age_r;
    wire       ctlWr = psel && penable && pready && pwrite && paddr == `ASR_OFF_CTRL;
    wire       setup = psel && !penable;

    // Shadow of the last control write; bit 1 may be cleared by hardware, so it is not compared
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrlSh_r <= 8'h00;
            age_r    <= 2'd0;
        end else if (ctlWr) begin
            ctrlSh_r <= pwdata[7:0];
            age_r    <= 2'd0;
        end else if (age_r != 2'd3) begin
            age_r    <= age_r + 2'd1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_ready_next: assert property (setup |=> pready)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_unmapped_err: assert property (setup && paddr > `ASR_OFF_DATA |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_ctrl_readback: assert property (pready && !pwrite && paddr == `ASR_OFF_CTRL |->
        prdata[31:2] == {24'h0, ctrlSh_r[7:2]})
        else $error("control readback differs");
    a_txoe_on: assert property (ctlWr && pwdata[3] |-> ##[1:3] txOe)
        else $error("tx pin not taken");
    a_idle_high: assert property (!txOe |-> txOut)
        else $error("released line not idle");
    a_break_low: assert property (ctlWr && pwdata[3] && pwdata[0] |-> ##[1:400] !txOut)
        else $error("break never started");
    a_sleep_quiet: assert property (age_r == 2'd3 && ctrlSh_r[7:4] == 4'h0 && ctrlSh_r[1] |-> !irqReq)
        else $error("interrupt while sleeping");
endmodule

bind asr_top asr_top_props u_props (.clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxPin(rxPin), .txOut(txOut), .txOe(txOe), .irqReq(irqReq));

/* File: bench/asr_remote.sv */
// Remote serial node: sends frames to the block and times low runs on its transmit line
`timescale 1ns/100ps
module asr_remote (
    // Clock
    input wire clk_sys,
    // Line from the block
    input wire txLine,
    // Line to the block
    output reg rxLine
);
    integer lowRun;
    integer lastLow;

    initial begin
        rxLine  = 1'b1;
        lowRun  = 0;
        lastLow = 0;
    end

    always @(posedge clk_sys) begin
        if (!txLine) begin
            lowRun <= lowRun + 1;
        end else if (lowRun != 0) begin
            lastLow <= lowRun;
            lowRun  <= 0;
        end
    end

    // 8N1 frame, 16 clocks a bit; a one-clock glitch mid-bit upsets exactly one sample
    task send(input [7:0] d, input [3:0] gBit, input stopVal);
        reg     [9:0] bits;
        integer       b;
        integer       c;
        begin
            bits = {stopVal, d, 1'b0};
            for (b = 0; b < 10; b = b + 1) begin
                for (c = 0; c < 16; c = c + 1) begin
                    @(posedge clk_sys);
                    rxLine <= bits[b] ^ (b == gBit && c == 9);
                end
            end
            @(posedge clk_sys);
            rxLine <= 1'b1;
        end
    endtask
endmodule

/* File: bench/tb_asr_top.sv */
// Self-checking bench for the serial block
`timescale 1ns/100ps
`include "asr_map.vh"
module tb_asr_top;
    reg         clk_sys;
    reg         rst;
    reg  [7:0]  paddr;
    reg         psel;
    reg         penable;
    reg         pwrite;
    reg  [31:0] pwdata;
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    wire        rxPin;
    wire        txOut;
    wire        txOe;
    wire        irqReq;
    wire        txLine = txOe ? txOut : 1'b1;
    integer     n_fail;
    integer     comparisons;
    integer     i;
    reg  [31:0] seed;
    reg  [31:0] rd;
    reg  [7:0]  v;
    reg         err;

    asr_top uut (.clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rxPin(rxPin), .txOut(txOut), .txOe(txOe), .irqReq(irqReq));
    asr_remote remote (.clk_sys(clk_sys), .txLine(txLine), .rxLine(rxPin));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t  = s ^ (s << 13);
            t  = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction

    task check(input [31:0] seen, input [31:0] exp, input [63:0] what);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask

    task apb(input wr, input [7:0] a, input [31:0] d);
        begin
            @(posedge clk_sys);
            psel    <= 1'b1;
            pwrite  <= wr;
            paddr   <= a;
            pwdata  <= d;
            @(posedge clk_sys);
            penable <= 1'b1;
            @(posedge clk_sys);
            while (pready !== 1'b1) begin
                @(posedge clk_sys);
            end
            rd = prdata;
            err = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task rdchk(input [7:0] a, input [31:0] exp);
        begin
            apb(1'b0, a, 32'h0);
            check(rd, exp, "read");
        end
    endtask

    task complete_run;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, n_fail);
            if (n_fail == 0 && comparisons > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    initial begin
        #500000;
        n_fail = n_fail + 1;
        complete_run;
    end

    // Receive cases: glitched bit (15 = none), stop level, expected noise and framing
    localparam [23:0] GL = 24'hf9903f;
    localparam [5:0]  SV = 6'b001111;
    localparam [5:0]  NZ = 6'b011110;
    localparam [5:0]  FR = 6'b110000;

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        n_fail = 0;
        comparisons = 0;
        seed = 32'h555a;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        rdchk(`ASR_OFF_CTRL, 32'h00);
        rdchk(`ASR_OFF_MASK, 32'hff);
        rdchk(`ASR_OFF_STAT, 32'hc0);
        rdchk(8'h18, 32'h0);
        check(err, 1'b1, "slverr");
        apb(1'b1, `ASR_OFF_BAUD, 32'h1);
        for (i = 0; i < 10; i = i + 1) begin
            seed = xs(seed);
            v = (i == 0) ? 8'h02 : seed[7:0] & 8'hf4;
            apb(1'b1, `ASR_OFF_CTRL, {24'h0, v});
            rdchk(`ASR_OFF_CTRL, {24'h0, v});
            check(irqReq, v[7] | v[6], "irq");
        end
        apb(1'b1, `ASR_OFF_CTRL, 32'h24);
        for (i = 0; i < 6; i = i + 1) begin
            seed = xs(seed);
            remote.send(seed[7:0], GL[4*i +: 4], SV[i]);
            repeat (8) @(posedge clk_sys);
            check(irqReq, 1'b1, "irq");
            apb(1'b0, `ASR_OFF_STAT, 32'h0);
            check(rd & 32'hef, {24'h0, 5'b11100, NZ[i], FR[i], 1'b0}, "status");
            rdchk(`ASR_OFF_DATA, {24'h0, seed[7:0]});
            repeat (2) @(posedge clk_sys);
            check(irqReq, 1'b0, "irq");
        end
        remote.send(8'h5a, 4'hf, 1'b1);
        remote.send(8'ha5, 4'hf, 1'b1);
        apb(1'b0, `ASR_OFF_STAT, 32'h0);
        check(rd & 32'hef, 32'he8, "overrun");
        rdchk(`ASR_OFF_DATA, 32'h5a);
        apb(1'b1, `ASR_OFF_CTRL, 32'h34);
        repeat (200) @(posedge clk_sys);
        check(irqReq, 1'b1, "quiet");
        rdchk(`ASR_OFF_STAT, 32'hd0);
        apb(1'b1, `ASR_OFF_CTRL, 32'h20);
        remote.send(8'h33, 4'hf, 1'b1);
        rdchk(`ASR_OFF_STAT, 32'hc0);
        apb(1'b1, `ASR_OFF_CTRL, 32'h26);
        remote.send(8'h66, 4'hf, 1'b1);
        repeat (8) @(posedge clk_sys);
        check(irqReq, 1'b0, "irq");
        repeat (200) @(posedge clk_sys);
        rdchk(`ASR_OFF_CTRL, 32'h24);
        apb(1'b1, `ASR_OFF_CTRL, 32'h08);
        repeat (200) @(posedge clk_sys);
        check({txOe, txOut}, 2'b11, "preamb");
        apb(1'b1, `ASR_OFF_DATA, 32'h0);
        repeat (200) @(posedge clk_sys);
        check(remote.lastLow, 144, "frame");
        for (i = 0; i < 2; i = i + 1) begin
            apb(1'b1, `ASR_OFF_AUX, i);
            apb(1'b1, `ASR_OFF_CTRL, 32'h09);
            apb(1'b1, `ASR_OFF_CTRL, 32'h08);
            repeat (300) @(posedge clk_sys);
            check(remote.lastLow, (i == 0) ? 160 : 208, "break");
        end
        apb(1'b1, `ASR_OFF_AUX, 32'h0);
        apb(1'b1, `ASR_OFF_CTRL, 32'h09);
        repeat (250) @(posedge clk_sys);
        check(txOut, 1'b0, "brkrep");
        apb(1'b1, `ASR_OFF_CTRL, 32'h00);
        repeat (400) @(posedge clk_sys);
        check({txOe, txOut}, 2'b01, "txoff");
        complete_run;
    end
endmodule
